// ---- logic/bwlm_defs.svh ----
`ifndef BWLM_DEFS_SVH
`define BWLM_DEFS_SVH
`define BWLM_LANE_W 9
`define BWLM_DATA_W 18
`define BWLM_ADDR_W 18
`define BWLM_LANES 2
`define BWLM_BURST 4
`define BWLM_FIFO_DEPTH 2
`define BWLM_CLK_NS 100
`define BWLM_K_PERIOD_NS 800
`define BWLM_K_HALF ((`BWLM_K_PERIOD_NS) / (2 * `BWLM_CLK_NS))
`define BWLM_STRAP_WAIT 2'h3
// controller phase points within one k period of eight clocks
`define BWLM_PH_KUP 3'h1
`define BWLM_PH_ODD 3'h2
`define BWLM_PH_EVEN 3'h6
`define BWLM_PH_RDY 3'h6
`define BWLM_PH_SEL 3'h7
`define BWLM_PH_CAPA 3'h3
`define BWLM_PH_CAPB 3'h7
// controller write burst progress
`define BWLM_WB_IDLE 3'h0
`define BWLM_WB_WAIT 3'h1
`define BWLM_WB_W0 3'h2
`define BWLM_WB_W1 3'h3
`define BWLM_WB_W2 3'h4
`define BWLM_WB_W3 3'h5
// device read launch progress
`define BWLM_RD_IDLE 3'h0
`define BWLM_RD_W1 3'h1
`define BWLM_RD_W2 3'h2
`define BWLM_RD_W3 3'h3
`define BWLM_RD_END 3'h4
`endif

// ---- logic/bwlm_pkg.sv ----
`default_nettype none
package bwlm_pkg;
   // state code doubles as the index of the next word to capture
   typedef enum logic [1:0] {
      WS_IDLE = 2'b00,
      WS_W1 = 2'b01,
      WS_W2 = 2'b10,
      WS_W3 = 2'b11
   } bwlm_wst_t;
endpackage
`default_nettype wire

// ---- logic/bwlm_if.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bwlm_defs.svh"
interface bwlm_if #(
   parameter int W = `BWLM_DATA_W,
   parameter int AW = `BWLM_ADDR_W,
   parameter int LANES = `BWLM_LANES
);
   logic k;
   logic k_n;
   logic c;
   logic c_n;
   logic write_port_select_n;
   logic read_port_select_n;
   logic [AW-1:0] addr;
   logic [W-1:0] d;
   logic [LANES-1:0] byte_lane_select_n;
   logic [W-1:0] q;
   logic q_oe;
   modport dev (
      input k, k_n, c, c_n, write_port_select_n, read_port_select_n,
      input addr, d, byte_lane_select_n,
      output q, q_oe
   );
   modport ctl (
      output k, k_n, c, c_n, write_port_select_n, read_port_select_n,
      output addr, d, byte_lane_select_n,
      input q, q_oe
   );
endinterface
`default_nettype wire

// ---- logic/bwlm_sram_dev.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bwlm_defs.svh"
module bwlm_sram_dev
   import bwlm_pkg::*;
#(
   parameter int W = `BWLM_DATA_W,
   parameter int AW = `BWLM_ADDR_W,
   parameter int LANES = `BWLM_LANES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   bwlm_if.dev lnk,
   output logic o_commit,
   output logic [AW-1:0] o_commit_addr,
   output logic o_single_clk
);
   localparam int BW = `BWLM_BURST * W;
   localparam int BL = `BWLM_BURST * LANES;
   localparam int SW = 6 + LANES + AW + W;

   logic [SW-1:0] s1_r;
   logic [SW-1:0] s2_r;
   logic [3:0] clk_d_r;
   logic [1:0] strap_cnt_r;
   logic strap_done_r;
   logic rd_prev_r;
   logic wr_prev_r;
   logic wpend_r;
   logic [AW-1:0] a1_r;
   logic [AW-1:0] acta_r;
   bwlm_wst_t wst_r;
   bwlm_wst_t wst_nxt;
   logic [BW-1:0] wbuf_r;
   logic [BL-1:0] wen_r;
   logic [BW-1:0] bitm;
   logic [BW-1:0] mem [2**AW];
   logic [BW-1:0] rnext_r;
   logic [BW-1:0] rline_r;
   logic rpend_r;
   logic [2:0] rcnt_r;
   logic [W-1:0] q_r;
   logic q_oe_r;

   // every pin, clocks included, crosses through two flops first
   wire logic [SW-1:0] pins = {lnk.k, lnk.k_n, lnk.c, lnk.c_n,
      lnk.write_port_select_n, lnk.read_port_select_n,
      lnk.byte_lane_select_n, lnk.addr, lnk.d};
   wire logic [3:0] clk_s = s2_r[SW-1 -: 4];
   wire logic wps_s = s2_r[SW-5];
   wire logic rps_s = s2_r[SW-6];
   wire logic [LANES-1:0] bls_s = s2_r[W+AW +: LANES];
   wire logic [AW-1:0] addr_s = s2_r[W +: AW];
   wire logic [W-1:0] d_s = s2_r[W-1:0];
   wire logic [3:0] rise = clk_s & ~clk_d_r;
   wire logic kr = rise[3];
   wire logic kn = rise[2];
   wire logic launch_p = strap_done_r && (o_single_clk ? kr : rise[1]);
   wire logic launch_n = strap_done_r && (o_single_clk ? kn : rise[0]);

   // a select low right after an initiation on its own port is ignored, read wins a tie
   wire logic rd_go = kr && !rps_s && !rd_prev_r;
   wire logic wr_go = kr && !wps_s && !wr_prev_r && !rd_go;

   // word 0 on the k rise after initiation, then k_n, k, k_n
   wire logic wcap = (kr && ((wst_r == WS_IDLE && wpend_r) || wst_r == WS_W2)) ||
      (kn && (wst_r == WS_W1 || wst_r == WS_W3));
   wire logic [1:0] widx = wst_r;
   wire logic ld0 = launch_p && rpend_r;

   always_comb begin
      unique case (wst_r)
         WS_IDLE: wst_nxt = WS_W1;
         WS_W1: wst_nxt = WS_W2;
         WS_W2: wst_nxt = WS_W3;
         WS_W3: wst_nxt = WS_IDLE;
      endcase
   end

   // each captured lane select gates one 9-bit lane of its own word
   for (genvar g = 0; g < BL; g++) begin : g_lane
      assign bitm[g*`BWLM_LANE_W +: `BWLM_LANE_W] = {`BWLM_LANE_W{wen_r[g]}};
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s1_r <= '1;
         s2_r <= '1;
         clk_d_r <= 4'hF;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         clk_d_r <= clk_s;
      end
   end

   // the strap is read only once the synchronised pins are real
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         strap_cnt_r <= 2'h0;
         strap_done_r <= 1'b0;
         o_single_clk <= 1'b0;
      end else if (!strap_done_r) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == `BWLM_STRAP_WAIT) begin
            strap_done_r <= 1'b1;
            o_single_clk <= clk_s[1] & clk_s[0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rd_prev_r <= 1'b0;
         wr_prev_r <= 1'b0;
         wpend_r <= 1'b0;
         wst_r <= WS_IDLE;
         o_commit <= 1'b0;
      end else begin
         if (kr) begin
            rd_prev_r <= rd_go;
            wr_prev_r <= wr_go;
            wpend_r <= wr_go;
         end
         if (wcap) begin
            wst_r <= wst_nxt;
         end
         o_commit <= wcap && wst_r == WS_W3;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         a1_r <= '0;
         acta_r <= '0;
         o_commit_addr <= '0;
         wbuf_r <= '0;
         wen_r <= '0;
      end else begin
         if (wr_go) begin
            a1_r <= addr_s;
         end
         if (wcap && wst_r == WS_IDLE) begin
            acta_r <= a1_r;
         end
         if (wcap && wst_r == WS_W3) begin
            o_commit_addr <= acta_r;
         end
         if (wcap) begin
            wbuf_r[int'(widx)*W +: W] <= d_s;
            wen_r[int'(widx)*LANES +: LANES] <= ~bls_s;
         end
      end
   end

   // whole burst lands at once; unselected lanes keep the old contents
   always_ff @(posedge i_clk) begin
      if (o_commit) begin
         mem[o_commit_addr] <= (mem[o_commit_addr] & ~bitm) | (wbuf_r & bitm);
      end
   end

   // second line buffer lets a read every other cycle overlap the last
   always_ff @(posedge i_clk) begin
      if (rd_go) begin
         rnext_r <= mem[addr_s];
      end
      if (ld0) begin
         rline_r <= rnext_r;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rpend_r <= 1'b0;
         rcnt_r <= `BWLM_RD_IDLE;
         q_r <= '0;
         q_oe_r <= 1'b0;
      end else begin
         rpend_r <= rd_go | (rpend_r & !launch_p);
         if (ld0) begin
            q_r <= rnext_r[W-1:0];
            q_oe_r <= 1'b1;
            rcnt_r <= `BWLM_RD_W1;
         end else if (launch_p && rcnt_r == `BWLM_RD_W2) begin
            q_r <= rline_r[2*W +: W];
            rcnt_r <= `BWLM_RD_W3;
         end else if (launch_p && rcnt_r == `BWLM_RD_END) begin
            q_oe_r <= 1'b0;
            rcnt_r <= `BWLM_RD_IDLE;
         end else if (launch_n && rcnt_r == `BWLM_RD_W1) begin
            q_r <= rline_r[W +: W];
            rcnt_r <= `BWLM_RD_W2;
         end else if (launch_n && rcnt_r == `BWLM_RD_W3) begin
            q_r <= rline_r[3*W +: W];
            rcnt_r <= `BWLM_RD_END;
         end
      end
   end

   assign lnk.q = q_r;
   assign lnk.q_oe = q_oe_r;
endmodule
`default_nettype wire

// ---- logic/bwlm_sram_ctl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bwlm_defs.svh"
module bwlm_sram_ctl
   import bwlm_pkg::*;
#(
   parameter int W = `BWLM_DATA_W,
   parameter int AW = `BWLM_ADDR_W,
   parameter int LANES = `BWLM_LANES,
   parameter int DEPTH = `BWLM_FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic i_wr_first,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [W-1:0] i_wr_data,
   input wire logic [LANES-1:0] i_wr_lane_n,
   input wire logic i_rd_valid,
   output logic o_rd_ready,
   input wire logic [AW-1:0] i_rd_addr,
   output logic o_rd_valid,
   output logic [W-1:0] o_rd_data,
   bwlm_if.ctl lnk
);
   localparam int FW = 1 + AW + LANES + W;
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [FW-1:0] fifo_r [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [2:0] phase_r;
   logic k_r;
   logic kn_r;
   logic wps_r;
   logic rps_r;
   logic [AW-1:0] addr_r;
   logic [W-1:0] d_r;
   logic [LANES-1:0] bls_r;
   logic st_last_r;
   logic nxt_r;
   logic [2:0] bcnt_r;
   logic [2:0] rcnt_r;
   logic [W:0] q1_r;
   logic [W:0] q2_r;

   wire logic [2:0] phase_nxt = phase_r + 3'h1;
   // k rises a clock after selects and address move, so the far end never syncs them on one edge
   wire logic k_nxt = phase_nxt >= `BWLM_PH_KUP && phase_nxt < `BWLM_PH_KUP + 3'(`BWLM_K_HALF);
   wire logic [FW-1:0] head = fifo_r[rp_r];
   wire logic hv = cnt_r != '0;
   wire logic h_first = head[FW-1];
   wire logic [AW-1:0] h_addr = head[W+LANES +: AW];
   wire logic [LANES-1:0] h_lane_n = head[W +: LANES];
   wire logic [W-1:0] h_data = head[W-1:0];
   wire logic push = i_wr_valid && o_wr_ready;
   wire logic sel = phase_r == `BWLM_PH_SEL;
   wire logic rd_take = sel && i_rd_valid && o_rd_ready;
   // never start on two consecutive k rises
   wire logic wr_take = sel && !st_last_r && hv && h_first && !rd_take;
   wire logic iss = (phase_r == `BWLM_PH_ODD && (bcnt_r == `BWLM_WB_W1 || bcnt_r == `BWLM_WB_W3)) ||
      (phase_r == `BWLM_PH_EVEN && (bcnt_r == `BWLM_WB_W0 || bcnt_r == `BWLM_WB_W2));
   // a missing follow-on word goes out with every lane deselected
   wire logic take = iss && hv && (bcnt_r == `BWLM_WB_W0 || !h_first);
   wire logic cap = rcnt_r != `BWLM_RD_IDLE &&
      ((phase_r == `BWLM_PH_CAPB && (rcnt_r == 3'h4 || rcnt_r == 3'h6)) ||
      (phase_r == `BWLM_PH_CAPA && (rcnt_r == 3'h5 || rcnt_r == 3'h7)));

   assign cnt_nxt = cnt_r + CW'(push) - CW'(take);

   always_ff @(posedge i_clk) begin
      if (push) begin
         fifo_r[wp_r] <= {i_wr_first, i_wr_addr, i_wr_lane_n, i_wr_data};
      end
   end

   // ready follows the fill level so a stalled link back-pressures the user
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         o_wr_ready <= 1'b0;
      end else begin
         if (push) begin
            wp_r <= (int'(wp_r) == DEPTH - 1) ? '0 : wp_r + PW'(1);
         end
         if (take) begin
            rp_r <= (int'(rp_r) == DEPTH - 1) ? '0 : rp_r + PW'(1);
         end
         cnt_r <= cnt_nxt;
         o_wr_ready <= int'(cnt_nxt) != DEPTH;
      end
   end

   // k runs free from this clock; c pins stay high for single-clock mode
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         phase_r <= 3'h0;
         k_r <= 1'b0;
         kn_r <= 1'b1;
      end else begin
         phase_r <= phase_nxt;
         k_r <= k_nxt;
         kn_r <= !k_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wps_r <= 1'b1;
         rps_r <= 1'b1;
         addr_r <= '0;
         st_last_r <= 1'b0;
         o_rd_ready <= 1'b0;
      end else begin
         o_rd_ready <= phase_r == `BWLM_PH_RDY && !st_last_r && rcnt_r == `BWLM_RD_IDLE;
         if (sel) begin
            wps_r <= !wr_take;
            rps_r <= !rd_take;
            st_last_r <= wr_take || rd_take;
            if (rd_take) begin
               addr_r <= i_rd_addr;
            end else if (wr_take) begin
               addr_r <= h_addr;
            end
         end else if (phase_r == `BWLM_PH_ODD) begin
            wps_r <= 1'b1;
            rps_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         bcnt_r <= `BWLM_WB_IDLE;
         nxt_r <= 1'b0;
         d_r <= '0;
         bls_r <= '1;
      end else begin
         if (iss) begin
            d_r <= h_data;
            bls_r <= take ? h_lane_n : '1;
         end
         if (wr_take) begin
            if (bcnt_r == `BWLM_WB_IDLE) begin
               bcnt_r <= `BWLM_WB_WAIT;
            end else begin
               nxt_r <= 1'b1;
            end
         end else if (phase_r == `BWLM_PH_ODD && bcnt_r == `BWLM_WB_W3) begin
            bcnt_r <= nxt_r ? `BWLM_WB_W0 : `BWLM_WB_IDLE;
            nxt_r <= 1'b0;
         end else if (iss || (phase_r == `BWLM_PH_ODD && bcnt_r == `BWLM_WB_WAIT)) begin
            bcnt_r <= bcnt_r + 3'h1;
         end
      end
   end

   // read words arrive through the far end's sync plus ours
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         q1_r <= '0;
         q2_r <= '0;
         rcnt_r <= `BWLM_RD_IDLE;
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
      end else begin
         q1_r <= {lnk.q_oe, lnk.q};
         q2_r <= q1_r;
         if (rd_take) begin
            rcnt_r <= 3'h1;
         end else if (rcnt_r != `BWLM_RD_IDLE &&
               (phase_r == `BWLM_PH_CAPA || phase_r == `BWLM_PH_CAPB)) begin
            rcnt_r <= rcnt_r + 3'h1;
         end
         o_rd_valid <= cap && q2_r[W];
         if (cap) begin
            o_rd_data <= q2_r[W-1:0];
         end
      end
   end

   assign lnk.k = k_r;
   assign lnk.k_n = kn_r;
   assign lnk.c = 1'b1;
   assign lnk.c_n = 1'b1;
   assign lnk.write_port_select_n = wps_r;
   assign lnk.read_port_select_n = rps_r;
   assign lnk.addr = addr_r;
   assign lnk.d = d_r;
   assign lnk.byte_lane_select_n = bls_r;
endmodule
`default_nettype wire

// ---- tb/bwlm_link_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bwlm_defs.svh"
module bwlm_link_assertions #(
   parameter int W = `BWLM_DATA_W,
   parameter int AW = `BWLM_ADDR_W,
   parameter int LANES = `BWLM_LANES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic k,
   input wire logic k_n,
   input wire logic c,
   input wire logic c_n,
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic [AW-1:0] addr,
   input wire logic [W-1:0] d,
   input wire logic [LANES-1:0] byte_lane_select_n,
   input wire logic [W-1:0] q,
   input wire logic q_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   chk_clk_pair_inverse: assert property (k_n != k)
      else $error("link clock pair not complementary");
   chk_strap_both_high: assert property (c && c_n)
      else $error("output clock strap not held high");
   chk_wr_start_spacing: assert property ($rose(k) && !write_port_select_n |-> ##8 write_port_select_n)
      else $error("write started on consecutive k rises");
   chk_rd_start_spacing: assert property ($rose(k) && !read_port_select_n |-> ##8 read_port_select_n)
      else $error("read started on consecutive k rises");
   chk_reset_deselected: assert property ($rose(i_nrst) |-> write_port_select_n && read_port_select_n && !q_oe)
      else $error("ports not deselected after reset");
   // output bus must stay driven for nine cycles once launched, over three words of the burst, not a single beat
   chk_rd_burst_window: assert property ($rose(k) && !read_port_select_n |-> ##[6:14] q_oe ##1 q_oe[*8])
      else $error("read burst not launched in t+1 and t+2");
   chk_data_held_rise: assert property ($rose(k) || $rose(k_n) |-> $stable(d) && $stable(byte_lane_select_n) ##1
      $stable(d) && $stable(byte_lane_select_n))
      else $error("write word or lane selects moved around a capture edge");
   chk_addr_held_start: assert property ($rose(k) && !write_port_select_n |-> $stable(addr) ##1 $stable(addr))
      else $error("address moved at write initiation");
endmodule
`default_nettype wire

// ---- tb/burst_write_byte_lane_masking_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module burst_write_byte_lane_masking_tb_top;
   import bwlm_pkg::*;
   logic i_clk;
   logic i_nrst;
   logic i_wr_valid;
   logic i_wr_first;
   logic [17:0] i_wr_addr;
   logic [17:0] i_wr_data;
   logic [1:0] i_wr_lane_n;
   logic i_rd_valid;
   logic [17:0] i_rd_addr;
   wire logic o_wr_ready;
   wire logic o_rd_ready;
   wire logic o_rd_valid;
   wire logic [17:0] o_rd_data;
   wire logic o_commit;
   wire logic [17:0] o_commit_addr;
   wire logic o_single_clk;
   int mismatches;
   int samples_checked;
   logic [71:0] mem [logic [17:0]];
   logic [17:0] commits [$];

   bwlm_if lnk_if ();
   bwlm_sram_ctl bwlm_sram_ctl_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr_valid(i_wr_valid),
      .o_wr_ready(o_wr_ready), .i_wr_first(i_wr_first), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
      .i_wr_lane_n(i_wr_lane_n), .i_rd_valid(i_rd_valid), .o_rd_ready(o_rd_ready), .i_rd_addr(i_rd_addr),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .lnk(lnk_if.ctl));
   bwlm_sram_dev bwlm_sram_dev_i (.i_clk(i_clk), .i_nrst(i_nrst), .lnk(lnk_if.dev), .o_commit(o_commit),
      .o_commit_addr(o_commit_addr), .o_single_clk(o_single_clk));
   bwlm_link_assertions bwlm_link_assertions_i (.i_clk(i_clk), .i_nrst(i_nrst), .k(lnk_if.k), .k_n(lnk_if.k_n),
      .c(lnk_if.c), .c_n(lnk_if.c_n), .write_port_select_n(lnk_if.write_port_select_n),
      .read_port_select_n(lnk_if.read_port_select_n), .addr(lnk_if.addr), .d(lnk_if.d),
      .byte_lane_select_n(lnk_if.byte_lane_select_n), .q(lnk_if.q), .q_oe(lnk_if.q_oe));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // commit is a one-cycle pulse and may land while a later burst is still queued
   always @(posedge i_clk) begin
      if (o_commit === 1'b1)
         commits.push_back(o_commit_addr);
   end

   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // word n of the line in bits n*18, lane g of word n in ln bit n*2+g
   task automatic wr_burst(input logic [17:0] a, input logic [71:0] dw, input logic [7:0] ln);
      int t;
      for (int n = 0; n < 4; n++) begin
         i_wr_valid <= 1'b1;
         i_wr_first <= (n == 0);
         i_wr_addr <= a;
         i_wr_data <= dw[n*18+:18];
         i_wr_lane_n <= ln[n*2+:2];
         t = 0;
         @(posedge i_clk);
         while (o_wr_ready !== 1'b1 && t < 300) begin
            @(posedge i_clk);
            t++;
         end
         check(t >= 300, 1'b0);
         for (int g = 0; g < 2; g++)
            if (!ln[n*2+g])
               mem[a][n*18+g*9+:9] = dw[n*18+g*9+:9];
      end
      i_wr_valid <= 1'b0;
      i_wr_first <= 1'b0;
      // one idle edge so a following burst never reassigns valid in the same step
      @(posedge i_clk);
   endtask

   task automatic expect_commits(input logic [17:0] a0, input logic [17:0] a1, input int n);
      int t;
      t = 0;
      while (commits.size() < n && t < 600) begin
         @(posedge i_clk);
         t++;
      end
      check(commits.size(), n);
      if (commits.size() > 0)
         check(commits.pop_front(), a0);
      if (n > 1 && commits.size() > 0)
         check(commits.pop_front(), a1);
   endtask

   task automatic verify_line(input logic [17:0] a);
      int t;
      logic [71:0] line;
      i_rd_valid <= 1'b1;
      i_rd_addr <= a;
      t = 0;
      @(posedge i_clk);
      while (o_rd_ready !== 1'b1 && t < 100) begin
         @(posedge i_clk);
         t++;
      end
      check(t >= 100, 1'b0);
      i_rd_valid <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         t = 0;
         @(posedge i_clk);
         while (o_rd_valid !== 1'b1 && t < 100) begin
            @(posedge i_clk);
            t++;
         end
         check(t >= 100, 1'b0);
         line[n*18+:18] = o_rd_data;
      end
      check(line, mem[a]);
   endtask

   task automatic t_power_up();
      check({lnk_if.write_port_select_n, lnk_if.read_port_select_n, lnk_if.q_oe}, 3'h6);
      repeat (8) @(posedge i_clk);
      check({o_single_clk, lnk_if.c, lnk_if.c_n}, 3'h7);
      $display("done: power up");
   endtask

   task automatic t_full_write();
      wr_burst(18'h00123, 72'hA5A5_3C3C_C3C3_5A5A_0F, 8'h00);
      expect_commits(18'h00123, 18'h00000, 1);
      verify_line(18'h00123);
      $display("done: full write");
   endtask

   // lower lane only, upper lane only, nothing, both: lanes change word by word
   task automatic t_lane_mix();
      wr_burst(18'h00123, 72'h1234_5678_9ABC_DEF0_12, 8'h36);
      expect_commits(18'h00123, 18'h00000, 1);
      verify_line(18'h00123);
      $display("done: lane mix");
   endtask

   task automatic t_back_to_back();
      // the second burst hits the same line with every lane off, so the line must survive it
      wr_burst(18'h3FFFF, 72'hFFFF_F000_00FF_FFF0_00, 8'h00);
      wr_burst(18'h3FFFF, 72'h8118_1818_8181_1818_81, 8'hFF);
      expect_commits(18'h3FFFF, 18'h3FFFF, 2);
      verify_line(18'h3FFFF);
      $display("done: back to back");
   endtask

   initial begin
      mismatches = 0;
      samples_checked = 0;
      i_nrst = 1'b0;
      i_wr_valid = 1'b0;
      i_wr_first = 1'b0;
      i_wr_addr = 18'h00000;
      i_wr_data = 18'h00000;
      i_wr_lane_n = 2'h3;
      i_rd_valid = 1'b0;
      i_rd_addr = 18'h00000;
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_power_up();
      t_full_write();
      t_lane_mix();
      t_back_to_back();
      report_and_stop();
   end

   // the four tests need a few hundred cycles in all
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      report_and_stop();
   end
endmodule
`default_nettype wire
